/* hdl/nctd_pkg.sv */
/*
  Constants, types and operand-field helpers for the nibble transfer core:
  register map, field positions, reset values, opcode patterns and the state record.
  Assumes a 13-bit instruction word and a nibble-wide data memory.
*/
// Overview of operation
// - two 4-bit data registers form one 8-bit pair, second one upper
// - both 16-bit index registers loadable only whole, upper and lower byte in one write
// - 8-bit extension register; writing it prepares the next instruction's operand
// - return stack pointer 16 bits, only bits 9..2 loadable as a byte
// - nibble stack pointer 16 bits, bits 7..0 loadable as a byte
// - 4-bit flag register (extension, interrupt, carry, zero) readable into first register
// - flag loads from first register or literal overwrite all four flags
// - every other transfer or swap clears extension flag, keeps the rest
// - post-increment forms add one to the index after it gave the address
// - single-cycle loads and stores; memory-to-memory copies take two cycles
// - register swap takes one cycle; register-memory swap takes two, swapping both
// - nibble literal 0..15 sits in the four lowest instruction bits
// - 6-bit short address selects low page or top I/O page nibble
// - signed byte literal is two's complement, -128 to 127
// - 4-bit count base operand encodes a base from 1 to 16
// - soft trap operand selects vector 0100H to 013FH
// - program counter is 16 bits wide, 65536-word program space
// - writing extension register sets extension flag; next instruction clears it
// - extension turns plain indexed access into absolute low or top page address
package nctd_pkg;

  // ==========================================================
  // register map (byte offsets on the Avalon slave)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PAIR = 8'h08;
  localparam logic [7:0] OFS_FLAG = 8'h0c;
  localparam logic [7:0] OFS_FIRST = 8'h10;
  localparam logic [7:0] OFS_SECOND = 8'h14;
  localparam logic [7:0] OFS_PREFIX = 8'h18;
  localparam logic [7:0] OFS_RSTACK = 8'h1c;
  localparam logic [7:0] OFS_NSTACK = 8'h20;
  localparam logic [7:0] OFS_PCNT = 8'h24;
  localparam logic [7:0] OFS_INSN = 8'h28;
  localparam logic [7:0] OFS_OPND = 8'h2c;
  localparam logic [7:0] OFS_PAGE = 8'h30;

  // ==========================================================
  // flag positions, pages and field constants
  localparam int FLAG_E = 3;
  localparam int FLAG_I = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_Z = 0;
  localparam logic [7:0] PAGE_LOW = 8'h00;
  localparam logic [7:0] PAGE_TOP = 8'hff;
  localparam logic [9:0] SHORT_LOW = 10'h000;
  localparam logic [9:0] SHORT_TOP = 10'h3ff;
  localparam logic [9:0] TRAP_BASE = 10'h004;
  localparam logic [4:0] BASE_OFFSET = 5'h01;

  // ==========================================================
  // opcode patterns (upper instruction bits)
  localparam logic [8:0] OP_RR = 9'h1ef;
  localparam logic [9:0] OP_MM = 10'h3df;
  localparam logic [12:0] OP_AF = 13'h1ff6;
  localparam logic [12:0] OP_FA = 13'h1ff5;
  localparam logic [12:0] OP_XAB = 13'h1ff7;
  localparam logic [7:0] OP_RI = 8'hf6;
  localparam logic [8:0] OP_FI = 9'h10b;
  localparam logic [9:0] OP_LDM = 10'h3dc;
  localparam logic [9:0] OP_STR = 10'h3dd;
  localparam logic [6:0] OP_STI = 7'h7a;
  localparam logic [9:0] OP_XM = 10'h21f;

  typedef enum logic [3:0] {
    K_NOP, K_RR, K_AF, K_FA, K_XAB, K_RI, K_FI, K_LDM, K_STR, K_STI, K_MM, K_XM
  } nctd_kind_t;

  typedef struct packed {
    logic [3:0] a;
    logic [3:0] b;
    logic [3:0] f;
    logic [3:0] tmp;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] sp1;
    logic [15:0] sp2;
    logic [15:0] pc;
    logic [7:0] upper_byte_prefix_reg;
    logic [12:0] ir;
    logic ir_valid;
    logic ph;
    logic step;
    logic run;
    logic ack;
    logic [31:0] rdata;
  } nctd_state_t;

  localparam nctd_state_t STATE_RST = '0;

  // ==========================================================
  // operand fields
  function automatic logic [3:0] nibble_literal(input logic [12:0] w);
    return w[3:0];
  endfunction

  function automatic logic [15:0] signed_byte_literal(input logic [12:0] w);
    return {{8{w[7]}}, w[7:0]};
  endfunction

  function automatic logic [15:0] short_page_address(input logic [12:0] w, input logic top);
    return {(top ? SHORT_TOP : SHORT_LOW), w[5:0]};
  endfunction

  function automatic logic [15:0] soft_trap_vector(input logic [12:0] w);
    return {TRAP_BASE, w[5:0]};
  endfunction

  function automatic logic [4:0] count_base_operand(input logic [12:0] w);
    return {1'b0, w[3:0]} + BASE_OFFSET;
  endfunction

  function automatic nctd_kind_t nctd_decode(input logic [12:0] w);
    nctd_kind_t k;
    k = K_NOP;
    if (w[12:4] == OP_RR && !w[3] && !w[0])
      k = K_RR;
    else if (w[12:3] == OP_MM)
      k = K_MM;
    else if (w == OP_AF)
      k = K_AF;
    else if (w == OP_FA)
      k = K_FA;
    else if (w == OP_XAB)
      k = K_XAB;
    else if (w[12:5] == OP_RI)
      k = K_RI;
    else if (w[12:4] == OP_FI)
      k = K_FI;
    else if (w[12:3] == OP_LDM)
      k = K_LDM;
    else if (w[12:3] == OP_STR)
      k = K_STR;
    else if (w[12:6] == OP_STI)
      k = K_STI;
    else if (w[12:3] == OP_XM)
      k = K_XM;
    return k;
  endfunction

endpackage

/* hdl/nctd_core.sv */
/*
  Transfer and exchange execution core: fetches 13-bit words, runs the nibble
  load and swap group against data memory, and exposes its state over Avalon-MM.
  Assumes program and data memory answer within the same clock as the address.
*/
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module nctd_core (
  input wire logic clk_i,
  input wire logic rstn_i,
  output logic [15:0] pm_addr_o,
  input wire logic [12:0] pm_data_i,
  output logic [15:0] dm_addr_o,
  output logic dm_rd_o,
  output logic dm_wr_o,
  output logic [3:0] dm_wdata_o,
  input wire logic [3:0] dm_rdata_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  import nctd_pkg::*;

  nctd_state_t s_reg;
  nctd_state_t s_next;
  nctd_kind_t kind;
  logic two;
  logic adv;
  logic last;
  logic use_y;
  logic post;
  logic ext_ok;
  logic idle;
  logic req;
  logic [3:0] lit;
  logic [31:0] rd_mux;

  // ==========================================================
  // decode
  always_comb
  begin
    kind = s_reg.ir_valid ? nctd_decode(s_reg.ir) : K_NOP;
    two = (kind == K_MM) || (kind == K_XM);
    adv = s_reg.run | s_reg.ph | s_reg.step;
    last = s_reg.ph & (s_reg.step | ~two);
    lit = nibble_literal(s_reg.ir);
    post = (kind == K_STI) ? s_reg.ir[4] : s_reg.ir[0];
    // a copy points at its source in the first step and at its destination in the second
    if (kind == K_STI)
      use_y = s_reg.ir[5];
    else if (kind == K_MM)
      use_y = s_reg.step ? ~s_reg.ir[1] : s_reg.ir[1];
    else
      use_y = s_reg.ir[1];
    // copy, register and post-increment forms ignore a pending extension
    ext_ok = s_reg.f[FLAG_E] & ~post &
             (kind == K_LDM || kind == K_STR || kind == K_STI || kind == K_XM);
    idle = ~s_reg.run & ~s_reg.ph & ~s_reg.step;
    req = avs_read_i | avs_write_i;
  end

  // ==========================================================
  // memory side
  always_comb
  begin
    pm_addr_o = s_reg.pc;
    if (ext_ok)
      dm_addr_o = {(use_y ? PAGE_TOP : PAGE_LOW), s_reg.upper_byte_prefix_reg};
    else
      dm_addr_o = use_y ? s_reg.y : s_reg.x;
    // the read strobe stands for both clocks of the read step, data is taken at its end
    dm_rd_o = adv & ~s_reg.step & (kind == K_LDM || kind == K_XM || kind == K_MM);
    dm_wr_o = adv & s_reg.ph & ((kind == K_STR || kind == K_STI) ||
                               ((kind == K_MM || kind == K_XM) & s_reg.step));
    if (kind == K_STI)
      dm_wdata_o = lit;
    else if (kind == K_MM)
      dm_wdata_o = s_reg.tmp;
    else
      dm_wdata_o = s_reg.ir[2] ? s_reg.b : s_reg.a;
    // exactly one wait state: ack toggles after each accepted request
    avs_waitrequest_o = req & ~s_reg.ack;
    avs_readdata_o = s_reg.rdata;
  end

  // ==========================================================
  // register read mux
  always_comb
  begin
    rd_mux = '0;
    case (avs_address_i)
      OFS_CTRL: rd_mux[0] = s_reg.run;
      OFS_STAT: rd_mux[3:0] = {s_reg.ir_valid, s_reg.step, s_reg.ph, s_reg.run};
      OFS_PAIR: rd_mux[7:0] = {s_reg.b, s_reg.a};
      OFS_FLAG: rd_mux[3:0] = s_reg.f;
      OFS_FIRST: rd_mux[15:0] = s_reg.x;
      OFS_SECOND: rd_mux[15:0] = s_reg.y;
      OFS_PREFIX: rd_mux[7:0] = s_reg.upper_byte_prefix_reg;
      OFS_RSTACK: rd_mux[15:0] = s_reg.sp1;
      OFS_NSTACK: rd_mux[15:0] = s_reg.sp2;
      OFS_PCNT: rd_mux[15:0] = s_reg.pc;
      // operand views of the latched word let software check field decoding
      OFS_INSN: rd_mux = {11'h000, count_base_operand(s_reg.ir), 3'h0, s_reg.ir};
      OFS_OPND: rd_mux = {soft_trap_vector(s_reg.ir), signed_byte_literal(s_reg.ir)};
      OFS_PAGE: rd_mux = {short_page_address(s_reg.ir, 1'b1),
                          short_page_address(s_reg.ir, 1'b0)};
      default: rd_mux = '0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    s_next = s_reg;
    if (adv)
    begin
      s_next.ph = ~s_reg.ph;
      if (s_reg.ph & two & ~s_reg.step)
        s_next.step = 1'b1;
      // the fetched nibble waits in tmp so the old register can be written back first
      if (s_reg.ph & ~s_reg.step & (kind == K_MM || kind == K_XM))
        s_next.tmp = dm_rdata_i;
      if (last)
      begin
        // any completed word drops a pending extension, even one outside the group
        if (s_reg.ir_valid)
          s_next.f[FLAG_E] = 1'b0;
        case (kind)
          K_RR:
          begin
            if (s_reg.ir[2])
              s_next.b = s_reg.ir[1] ? s_reg.b : s_reg.a;
            else
              s_next.a = s_reg.ir[1] ? s_reg.b : s_reg.a;
          end
          K_AF: s_next.a = s_reg.f;
          K_FA: s_next.f = s_reg.a;
          K_FI: s_next.f = lit;
          K_XAB:
          begin
            s_next.a = s_reg.b;
            s_next.b = s_reg.a;
          end
          K_RI:
          begin
            if (s_reg.ir[4])
              s_next.b = lit;
            else
              s_next.a = lit;
          end
          K_LDM:
          begin
            if (s_reg.ir[2])
              s_next.b = dm_rdata_i;
            else
              s_next.a = dm_rdata_i;
          end
          K_XM:
          begin
            if (s_reg.ir[2])
              s_next.b = s_reg.tmp;
            else
              s_next.a = s_reg.tmp;
          end
          default: s_next.tmp = s_reg.tmp;
        endcase
        // index bumps land after the address has been used
        if (kind == K_MM)
        begin
          if (s_reg.ir[0])
          begin
            if (s_reg.ir[1])
              s_next.y = s_reg.y + 16'h0001;
            else
              s_next.x = s_reg.x + 16'h0001;
          end
          if (s_reg.ir[2])
          begin
            if (s_reg.ir[1])
              s_next.x = s_reg.x + 16'h0001;
            else
              s_next.y = s_reg.y + 16'h0001;
          end
        end
        else if ((kind == K_LDM || kind == K_STR || kind == K_STI || kind == K_XM) && post)
        begin
          if (use_y)
            s_next.y = s_reg.y + 16'h0001;
          else
            s_next.x = s_reg.x + 16'h0001;
        end
        s_next.step = 1'b0;
        s_next.ir = pm_data_i;
        s_next.ir_valid = 1'b1;
        s_next.pc = s_reg.pc + 16'h0001;
      end
    end

    // bus slave: one wait state, then the access completes
    s_next.ack = req & ~s_reg.ack;
    if (avs_read_i & ~s_reg.ack)
      s_next.rdata = rd_mux;
    // pair, flag, index, stack and counter writes take effect only while halted at an instruction boundary; control and prefix writes at any time
    if (avs_write_i & s_reg.ack)
    begin
      case (avs_address_i)
        OFS_CTRL: s_next.run = avs_writedata_i[0];
        OFS_PREFIX:
        begin
          s_next.upper_byte_prefix_reg = avs_writedata_i[7:0];
          s_next.f[FLAG_E] = 1'b1;
        end
        OFS_PAIR:
        begin
          if (idle)
          begin
            s_next.a = avs_writedata_i[3:0];
            s_next.b = avs_writedata_i[7:4];
          end
        end
        OFS_FLAG:
        begin
          if (idle)
            s_next.f = avs_writedata_i[3:0];
        end
        OFS_FIRST:
        begin
          if (idle)
          begin
            s_next.x[15:8] = avs_writedata_i[15:8];
            s_next.x[7:0] = avs_writedata_i[7:0];
          end
        end
        OFS_SECOND:
        begin
          if (idle)
          begin
            s_next.y[15:8] = avs_writedata_i[15:8];
            s_next.y[7:0] = avs_writedata_i[7:0];
          end
        end
        OFS_RSTACK:
        begin
          if (idle)
            s_next.sp1 = {6'h00, avs_writedata_i[7:0], 2'h0};
        end
        OFS_NSTACK:
        begin
          if (idle)
            s_next.sp2 = {8'h00, avs_writedata_i[7:0]};
        end
        OFS_PCNT:
        begin
          if (idle)
          begin
            s_next.pc = avs_writedata_i[15:0];
            s_next.ir_valid = 1'b0;
          end
        end
        default: s_next.upper_byte_prefix_reg = s_next.upper_byte_prefix_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      s_reg <= STATE_RST;
    else
      s_reg <= s_next;
  end

  // ==========================================================
  // checks
  // all checks share the core clock and stay quiet during reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // a prefix write on the edge that ends an instruction keeps the flag set
  logic ext_wr;
  assign ext_wr = avs_write_i & s_reg.ack & (avs_address_i == OFS_PREFIX);

  sequence mm_start;
    adv && kind == K_MM && !s_reg.ph && !s_reg.step;
  endsequence
  sequence mm_write;
    dm_wr_o && s_reg.step && s_reg.ph;
  endsequence

  a_mm_two_cycles: assert property (mm_start |-> ##3 mm_write)
    else $error("copy write not in fourth clock");
  a_flag_clear: assert property (adv && last && s_reg.ir_valid && kind != K_FA
                                  && kind != K_FI && !ext_wr |=> !s_reg.f[FLAG_E])
    else $error("extension flag left set");
  a_flag_load: assert property (adv && last && kind == K_FI && !ext_wr
                                |=> s_reg.f == $past(lit))
    else $error("flag literal load wrong");
  a_ext_set: assert property (ext_wr |=> s_reg.f[FLAG_E] && s_reg.upper_byte_prefix_reg == $past(avs_writedata_i[7:0]))
    else $error("prefix write did not set extension");
  a_post_inc: assert property (adv && last && kind == K_LDM && post && !use_y && !avs_write_i
                               |=> s_reg.x == $past(s_reg.x) + 16'h0001)
    else $error("first index not bumped");
  a_swap_mem: assert property (adv && kind == K_XM && s_reg.ph && !s_reg.step && !s_reg.ir[2]
                               |=> ##2 s_reg.a == $past(dm_rdata_i, 3))
    else $error("memory swap lost value");
  a_ext_addr: assert property ((dm_rd_o || dm_wr_o) && ext_ok
                               |-> dm_addr_o[15:8] == (use_y ? PAGE_TOP : PAGE_LOW))
    else $error("extended address page wrong");
  a_rstack_bits: assert property (s_reg.sp1[1:0] == 2'h0 && s_reg.sp1[15:10] == 6'h00)
    else $error("return stack pointer bits out of range");
  a_cycle_two_clk: assert property (adv && !s_reg.ph |=> s_reg.ph ##1 !s_reg.ph)
    else $error("instruction cycle not two clocks");

  // ==========================================================
  // timing and data checks of the one-cycle and swap forms
  sequence ld_start;
    adv && !s_reg.ph &&
      (kind == K_LDM || kind == K_STR || kind == K_STI || kind == K_RI || kind == K_RR);
  endsequence
  sequence xm_start;
    adv && kind == K_XM && !s_reg.ph && !s_reg.step && !s_reg.ir[2];
  endsequence
  sequence xab_end;
    adv && last && kind == K_XAB;
  endsequence

  a_one_cycle_ld: assert property (ld_start |=> last)
    else $error("single-cycle transfer ran long");
  a_swap_old_reg: assert property (xm_start
                                   |-> ##3 mm_write ##0 dm_wdata_o == $past(s_reg.a, 3))
    else $error("memory swap wrote wrong register value");
  a_pair_swap: assert property (xab_end
                                |=> s_reg.a == $past(s_reg.b) && s_reg.b == $past(s_reg.a))
    else $error("register swap wrong");
  // zero, carry and interrupt survive every transfer except the two flag loads
  a_flag_keep: assert property (adv && last && kind != K_FA && kind != K_FI
                                |=> s_reg.f[2:0] == $past(s_reg.f[2:0]))
    else $error("flag bits changed by transfer");
  a_pc_step: assert property (adv && last |=> pm_addr_o == $past(s_reg.pc) + 16'h0001)
    else $error("program counter did not advance");
endmodule

/* dv/nctd_mem.sv */
/*
  Partner model: program memory and nibble-wide data memory of the transfer core.
  Assumes both memories answer in the same clock as the address, as the core expects.
*/
`timescale 1ns/1ps
module nctd_mem (
  input wire logic clk_i,
  input wire logic [15:0] pm_addr_i,
  output logic [12:0] pm_data_o,
  input wire logic [15:0] dm_addr_i,
  input wire logic dm_rd_i,
  input wire logic dm_wr_i,
  input wire logic [3:0] dm_wdata_i,
  output logic [3:0] dm_rdata_o
);
  // ==========================================================
  // storage
  logic [12:0] pm [0:63];
  logic [3:0] dm [0:65535];
  logic [3:0] last_reg = 4'h0;

  initial foreach (pm[i]) pm[i] = 13'h0;

  // words outside the loaded window read as a no-op
  assign pm_data_o = (pm_addr_i < 16'h0040) ? pm[pm_addr_i[5:0]] : 13'h0;
  // a deselected data bus shows the inverse of the last nibble, never a stale copy
  assign dm_rdata_o = dm_rd_i ? dm[dm_addr_i] : ~last_reg;

  always @(posedge clk_i)
  begin
    if (dm_rd_i)
      last_reg <= dm[dm_addr_i];
    if (dm_wr_i)
      dm[dm_addr_i] <= dm_wdata_i;
  end
endmodule

/* dv/test_nibble_cpu_transfer_decode.sv */
/*
  Self-checking bench for the nibble transfer core: loads short programs into the
  memory model, runs them over the register bus and judges registers and memory.
  Assumes the one-wait-state bus answer and halting at instruction boundaries.
*/
`timescale 1ns/1ps
module test_nibble_cpu_transfer_decode;
  import nctd_pkg::*;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [15:0] pm_addr_o;
  logic [12:0] pm_data_i;
  logic [15:0] dm_addr_o;
  logic dm_rd_o;
  logic dm_wr_o;
  logic [3:0] dm_wdata_o;
  logic [3:0] dm_rdata_i;
  int err_total = 0;
  int comparisons = 0;
  int hits [0:15];
  logic counting = 1'b0;

  always #10 clk_i = ~clk_i;
  // clocks spent at each program address give the length of the previous instruction
  always @(posedge clk_i)
    if (counting)
      hits[pm_addr_o[3:0]]++;

  nctd_core nctd_core_i (.clk_i(clk_i), .rstn_i(rstn_i), .pm_addr_o(pm_addr_o),
    .pm_data_i(pm_data_i), .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o), .dm_wr_o(dm_wr_o),
    .dm_wdata_o(dm_wdata_o), .dm_rdata_i(dm_rdata_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
  nctd_mem nctd_mem_i (.clk_i(clk_i), .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i),
    .dm_addr_i(dm_addr_o), .dm_rd_i(dm_rd_o), .dm_wr_i(dm_wr_o), .dm_wdata_i(dm_wdata_o),
    .dm_rdata_o(dm_rdata_i));

  // ==========================================================
  // bus and run helpers
  task automatic av_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    // hold until the rising edge that samples waitrequest low; only the watchdog ends a hang
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clk_i);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic av_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    av_xfer(a, 1'b1, d, q);
  endtask

  task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    logic [31:0] q;
    av_xfer(a, 1'b0, 32'h0, q);
    `CHK(n, e, q & m)
  endtask

  task automatic setst(input logic [7:0] p, input logic [3:0] f, input logic [15:0] x,
    input logic [15:0] y);
    av_wr(OFS_PAIR, {24'h0, p});
    av_wr(OFS_FLAG, {28'h0, f});
    av_wr(OFS_FIRST, {16'h0, x});
    av_wr(OFS_SECOND, {16'h0, y});
  endtask

  task automatic run_prog(input logic [12:0] w0, input logic [12:0] w1, input logic [12:0] w2);
    foreach (hits[i]) hits[i] = 0;
    nctd_mem_i.pm[0] = w0;
    nctd_mem_i.pm[1] = w1;
    nctd_mem_i.pm[2] = w2;
    av_wr(OFS_PCNT, 32'h0);
    counting = 1'b1;
    av_wr(OFS_CTRL, 32'h1);
    repeat (24) @(posedge clk_i);
    av_wr(OFS_CTRL, 32'h0);
    counting = 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_regs;
    `CHK("pc_rst", 16'h0000, pm_addr_o)
    chk_rd("pair_rst", OFS_PAIR, 32'h0, 32'hff);
    av_wr(OFS_FIRST, 32'habcd);
    chk_rd("first_rw", OFS_FIRST, 32'habcd, 32'hffff);
    av_wr(8'hfc, 32'h5);
    chk_rd("unmapped", 8'hfc, 32'h0, 32'hffffffff);
    av_wr(OFS_RSTACK, 32'h1ff);
    chk_rd("rstack", OFS_RSTACK, 32'h3fc, 32'hffff);
    av_wr(OFS_NSTACK, 32'h3ff);
    chk_rd("nstack", OFS_NSTACK, 32'hff, 32'hffff);
  endtask

  task automatic sc_load;
    // extension stays clear: post-increment forms must not carry it
    setst(8'h00, 4'h7, 16'h1230, 16'h0000);
    nctd_mem_i.dm[16'h1230] = 4'ha;
    nctd_mem_i.dm[16'h1231] = 4'h5;
    run_prog(13'h1ee1, 13'h1ee4, 13'h0000);
    chk_rd("pair", OFS_PAIR, 32'h5a, 32'hff);
    chk_rd("x_inc", OFS_FIRST, 32'h1231, 32'hffff);
    chk_rd("flags", OFS_FLAG, 32'h7, 32'hf);
    `CHK("cyc_ld", 32'h2, hits[1])
  endtask

  task automatic sc_copy;
    setst(8'hc3, 4'h0, 16'h3000, 16'h2000);
    nctd_mem_i.dm[16'h2000] = 4'h9;
    run_prog(13'h1eff, 13'h1eef, 13'h1e86);
    `CHK("copy", 4'h9, nctd_mem_i.dm[16'h3000])
    `CHK("st_b", 4'hc, nctd_mem_i.dm[16'h2001])
    `CHK("st_lit", 4'h6, nctd_mem_i.dm[16'h3001])
    chk_rd("x_end", OFS_FIRST, 32'h3001, 32'hffff);
    chk_rd("y_end", OFS_SECOND, 32'h2002, 32'hffff);
    `CHK("cyc_cp", 32'h4, hits[1])
    `CHK("cyc_st", 32'h2, hits[2])
  endtask

  task automatic sc_swap;
    setst(8'h84, 4'h0, 16'h0100, 16'h0000);
    nctd_mem_i.dm[16'h0100] = 4'he;
    run_prog(13'h10f9, 13'h1ff7, 13'h0000);
    `CHK("swap_mem", 4'h4, nctd_mem_i.dm[16'h0100])
    chk_rd("swap_pair", OFS_PAIR, 32'he8, 32'hff);
    chk_rd("swap_x", OFS_FIRST, 32'h0101, 32'hffff);
    `CHK("cyc_xm", 32'h4, hits[1])
    `CHK("cyc_xab", 32'h2, hits[2])
  endtask

  task automatic sc_flag;
    setst(8'h00, 4'h7, 16'h0000, 16'h0000);
    run_prog(13'h1ff6, 13'h1ed5, 13'h10b4);
    chk_rd("a_from_f", OFS_PAIR, 32'h57, 32'hff);
    chk_rd("f_lit", OFS_FLAG, 32'h4, 32'hf);
    setst(8'h06, 4'h0, 16'h0000, 16'h0000);
    run_prog(13'h1ff5, 13'h0000, 13'h0000);
    chk_rd("f_from_a", OFS_FLAG, 32'h6, 32'hf);
  endtask

  // extension is only paired with plain indexed forms here
  task automatic sc_ext;
    setst(8'h30, 4'h0, 16'h4444, 16'h5555);
    av_wr(OFS_PREFIX, 32'h37);
    chk_rd("prefix", OFS_PREFIX, 32'h37, 32'hff);
    chk_rd("e_set", OFS_FLAG, 32'h8, 32'hf);
    nctd_mem_i.dm[16'h0037] = 4'hd;
    run_prog(13'h1ee0, 13'h0000, 13'h0000);
    chk_rd("ext_ld", OFS_PAIR, 32'h3d, 32'hff);
    chk_rd("e_clr", OFS_FLAG, 32'h0, 32'hf);
    nctd_mem_i.dm[16'h5555] = 4'h0;
    av_wr(OFS_PREFIX, 32'h9c);
    run_prog(13'h1eee, 13'h0000, 13'h0000);
    `CHK("ext_st", 4'h3, nctd_mem_i.dm[16'hff9c])
    `CHK("no_y_st", 4'h0, nctd_mem_i.dm[16'h5555])
  endtask

  // a word outside the group runs as a no-op and stays latched for the operand views
  task automatic sc_fields;
    for (int i = 0; i < 64; i++)
      nctd_mem_i.pm[i] = 13'h0a85;
    run_prog(13'h0a85, 13'h0a85, 13'h0a85);
    chk_rd("stat", OFS_STAT, 32'h8, 32'hf);
    chk_rd("insn", OFS_INSN, 32'h00060a85, 32'hffffffff);
    chk_rd("opnd_trap", OFS_OPND, 32'h01050000, 32'hffff0000);
    chk_rd("opnd_sign", OFS_OPND, 32'h0000ff85, 32'h0000ffff);
    chk_rd("page", OFS_PAGE, 32'hffc50005, 32'hffffffff);
  endtask

  // ==========================================================
  // verdict and sequence
  task automatic print_verdict;
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    sc_regs;
    sc_load;
    sc_copy;
    sc_swap;
    sc_flag;
    sc_ext;
    sc_fields;
    print_verdict;
  end

  // the sequence needs well under 2000 clocks
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    print_verdict;
  end
endmodule
